// file: hdl/erpc_map.svh
/*
 * Register map, field positions, reset values and widths of the
 * event range performance counter.
 * Assumes byte addressing on a 32-bit APB bus, one word per register.
 */
`ifndef ERPC_MAP_SVH
`define ERPC_MAP_SVH

`define ERPC_ADDR_W       8
`define ERPC_EV_W         8
`define ERPC_FULL_W       32
`define ERPC_RED_W        24

`define ERPC_OFS_CTRL     8'h00
`define ERPC_OFS_MODE0    8'h04
`define ERPC_OFS_START0   8'h08
`define ERPC_OFS_STOP0    8'h0C
`define ERPC_OFS_MODE1    8'h10
`define ERPC_OFS_START1   8'h14
`define ERPC_OFS_STOP1    8'h18
`define ERPC_OFS_CNT0     8'h20
`define ERPC_OFS_CNT1     8'h24
`define ERPC_OFS_STATUS   8'h28
`define ERPC_OFS_MASK     8'h2C
`define ERPC_OFS_STATE    8'h30

`define ERPC_CTRL_CASC    0
`define ERPC_CTRL_CLR0    1
`define ERPC_CTRL_CLR1    2

`define ERPC_ST_OVF0      0
`define ERPC_ST_OVF1      1
`define ERPC_ST_END0      2
`define ERPC_ST_END1      3
`define ERPC_ST_W         4

`define ERPC_MODE_W       4
`define ERPC_RST_CTRL     1'h0
`define ERPC_RST_MASK     4'h0
`define ERPC_RST_EVMASK   8'h00

`endif

// file: hdl/erpc_pkg.sv
/*
 * Types shared by the performance counter modules.
 * Assumes erpc_map.svh is on the include path.
 */
`include "erpc_map.svh"

package erpc_pkg;

   typedef enum logic [`ERPC_MODE_W-1:0] {
      ERPC_NONE,
      ERPC_EXEC_CYC,
      ERPC_SUP_CYC,
      ERPC_EXCIRQ_CYC,
      ERPC_EXC_CYC,
      ERPC_IRQ_CYC,
      ERPC_EXEC_CNT,
      ERPC_EXCIRQ_CNT,
      ERPC_EXC_CNT,
      ERPC_IRQ_CNT
   } erpc_mode_e;

   typedef logic [`ERPC_EV_W-1:0] erpc_ev_t;

endpackage

// file: hdl/erpc_rng_if.sv
/*
 * Carrier between the register block and one range engine.
 * Assumes a single clock domain shared by both ends.
 */
`timescale 1ns/1ps

interface erpc_rng_if;
   import erpc_pkg::*;

   erpc_mode_e mode;
   erpc_ev_t   start_mask;
   erpc_ev_t   stop_mask;
   logic       inc;
   logic       active;
   logic       pass_end;

   modport ctl (output mode, output start_mask, output stop_mask,
                input inc, input active, input pass_end);
   modport rng (input mode, input start_mask, input stop_mask,
                output inc, output active, output pass_end);
endinterface

// file: hdl/erpc_range.sv
/*
 * One measurement range: start/stop detection and the increment request.
 * Assumes all CPU status inputs are on sys_clk_i; pulses last one cycle.
 */
`timescale 1ns/1ps

module erpc_range
   import erpc_pkg::*;
(
   input  wire logic sys_clk_i,      // cpu clock
   input  wire logic reset_n_i,      // sync reset, low
   input  wire logic [`ERPC_EV_W-1:0] ev_match_i, // detector matches
   input  wire logic cpu_run_i,      // program executing
   input  wire logic cpu_super_i,    // supervisor mode
   input  wire logic exc_cyc_i,      // in exception processing
   input  wire logic irq_cyc_i,      // in interrupt processing
   input  wire logic instr_exec_i,   // instruction executed pulse
   input  wire logic exc_acc_i,      // exception accepted pulse
   input  wire logic irq_acc_i,      // interrupt accepted pulse
   erpc_rng_if.rng   rif             // settings and results
);

   logic run_d_r;
   logic active_r;
   logic seen_r;
   logic inc_r;
   logic end_r;
   logic start_hit;
   logic stop_hit;
   logic cyc_q;
   logic occ_q;
   logic is_cnt;

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) run_d_r <= 1'b0;
      else            run_d_r <= cpu_run_i;
   end

   always_comb begin
      // empty mask falls back to program start/stop
      start_hit = (rif.start_mask == '0) ? (cpu_run_i & ~run_d_r)
                                         : |(ev_match_i & rif.start_mask);
      stop_hit  = (rif.stop_mask == '0)  ? (~cpu_run_i & run_d_r)
                                         : |(ev_match_i & rif.stop_mask);
      cyc_q  = 1'b0;
      occ_q  = 1'b0;
      is_cnt = 1'b0;
      unique case (rif.mode)
         ERPC_NONE:       ;
         ERPC_EXEC_CYC:   cyc_q = cpu_run_i;
         ERPC_SUP_CYC:    cyc_q = cpu_run_i & cpu_super_i;
         ERPC_EXCIRQ_CYC: cyc_q = exc_cyc_i | irq_cyc_i;
         ERPC_EXC_CYC:    cyc_q = exc_cyc_i;
         ERPC_IRQ_CYC:    cyc_q = irq_cyc_i;
         ERPC_EXEC_CNT:   begin occ_q = instr_exec_i; is_cnt = 1'b1; end
         ERPC_EXCIRQ_CNT: begin occ_q = exc_acc_i | irq_acc_i; is_cnt = 1'b1; end
         ERPC_EXC_CNT:    begin occ_q = exc_acc_i; is_cnt = 1'b1; end
         ERPC_IRQ_CNT:    begin occ_q = irq_acc_i; is_cnt = 1'b1; end
         default:         ;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i || rif.mode == ERPC_NONE) active_r <= 1'b0;
      else if (active_r)                      active_r <= ~stop_hit;
      else                                    active_r <= start_hit;
   end

   // occurrence seen during the current pass
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i || !active_r) seen_r <= 1'b0;
      else if (stop_hit)           seen_r <= 1'b0;
      else if (occ_q)              seen_r <= 1'b1;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) inc_r <= 1'b0;
      else if (is_cnt) inc_r <= active_r & stop_hit & (seen_r | occ_q);
      else             inc_r <= active_r & cyc_q;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) end_r <= 1'b0;
      else            end_r <= active_r & stop_hit;
   end

   assign rif.inc      = inc_r;
   assign rif.active   = active_r;
   assign rif.pass_end = end_r;

endmodule

// file: hdl/erpc_cnt.sv
/*
 * Holding up-counter with clear and carry-out.
 * Assumes clear and increment are same-clock single-cycle requests.
 */
`timescale 1ns/1ps

module erpc_cnt #(
   parameter int W = 32
) (
   input  wire logic         sys_clk_i,  // cpu clock
   input  wire logic         reset_n_i,  // sync reset, low
   input  wire logic         clr_i,      // clear request
   input  wire logic         inc_i,      // add one
   output logic [W-1:0]      cnt_o,      // count value
   output logic              carry_o     // wraps this cycle
);

   logic [W-1:0] cnt_r;

   // value holds while idle; clr_i, reset or a wrap past all ones zero it
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i || clr_i) cnt_r <= '0;
      else if (inc_i)          cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
   end

   assign cnt_o   = cnt_r;
   assign carry_o = inc_i & ~clr_i & (&cnt_r);

endmodule

// file: hdl/erpc_top.sv
/*
 * Event range performance counter with APB register access.
 * Assumes all CPU status inputs come from logic on sys_clk_i.
 */
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps

// Functional notes
// - full variant: two ranges, 32-bit each
// - cascade joins both into 64-bit counter
// - cascade ignores second range settings
// - reduced variant: one range, 24-bit counter
// - one mode per range; none disables
// - cycle modes pick which cycles count
// - count modes pick which occurrences count
// - range bounds come from event detectors
// - cycles count from start until stop
// - count mode adds one per pass with an occurrence
// - start events combine as OR
// - no start event: program start begins
// - stop events OR; none: program stop ends
// - sticky overflow flag on counter wrap
module erpc_top
   import erpc_pkg::*;
#(
   parameter bit REDUCED = 1'b0
) (
   input  wire logic                    sys_clk_i,    // cpu clock, 25 MHz
   input  wire logic                    reset_n_i,    // sync reset, low
   input  wire logic                    psel_i,       // apb select
   input  wire logic                    penable_i,    // apb access phase
   input  wire logic                    pwrite_i,     // apb write
   input  wire logic [`ERPC_ADDR_W-1:0] paddr_i,      // apb byte address
   input  wire logic [31:0]             pwdata_i,     // apb write data
   output logic [31:0]                  prdata_o,     // apb read data
   output logic                         pready_o,     // apb ready
   output logic                         pslverr_o,    // apb error
   input  wire logic [`ERPC_EV_W-1:0]   ev_match_i,   // detector matches
   input  wire logic                    cpu_run_i,    // program executing
   input  wire logic                    cpu_super_i,  // supervisor mode
   input  wire logic                    exc_cyc_i,    // exception cycle
   input  wire logic                    irq_cyc_i,    // interrupt cycle
   input  wire logic                    instr_exec_i, // instruction pulse
   input  wire logic                    exc_acc_i,    // exception accepted
   input  wire logic                    irq_acc_i,    // interrupt accepted
   output logic                         irq_o         // level interrupt
);

   localparam int CW = REDUCED ? `ERPC_RED_W : `ERPC_FULL_W;
   localparam int NR = REDUCED ? 1 : 2;

   erpc_rng_if rif [2] ();

   logic              casc_r;
   logic [1:0]        clr_r;
   erpc_mode_e        mode_r  [2];
   erpc_ev_t          start_r [2];
   erpc_ev_t          stop_r  [2];
   logic [`ERPC_ST_W-1:0] status_r;
   logic [`ERPC_ST_W-1:0] mask_r;
   logic [`ERPC_ST_W-1:0] ev_set;
   logic [31:0]       prdata_r;
   logic              pready_r;
   logic              pslverr_r;
   logic              irq_r;
   logic [CW-1:0]     cnt [2];
   logic [1:0]        carry;
   logic [1:0]        cnt_inc;
   logic [1:0]        act;
   logic [1:0]        pend;
   logic              acc;
   logic              wr;

   assign acc = psel_i & penable_i & ~pready_r;
   assign wr  = acc & pwrite_i;

   function automatic logic mapped(input logic [`ERPC_ADDR_W-1:0] a);
      unique case (a)
         `ERPC_OFS_CTRL, `ERPC_OFS_MODE0, `ERPC_OFS_START0, `ERPC_OFS_STOP0,
         `ERPC_OFS_MODE1, `ERPC_OFS_START1, `ERPC_OFS_STOP1, `ERPC_OFS_CNT0,
         `ERPC_OFS_CNT1, `ERPC_OFS_STATUS, `ERPC_OFS_MASK,
         `ERPC_OFS_STATE: mapped = 1'b1;
         default:         mapped = 1'b0;
      endcase
   endfunction

   function automatic erpc_mode_e to_mode(input logic [31:0] d);
      if (d[`ERPC_MODE_W-1:0] > ERPC_IRQ_CNT) to_mode = ERPC_NONE;
      else                                    to_mode = erpc_mode_e'(d[`ERPC_MODE_W-1:0]);
   endfunction

   // ---- control registers ----
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         casc_r <= `ERPC_RST_CTRL;
      end else if (wr && paddr_i == `ERPC_OFS_CTRL && !REDUCED) begin
         casc_r <= pwdata_i[`ERPC_CTRL_CASC];
      end
   end

   // counter clears are one-cycle strobes
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         clr_r <= 2'h0;
      end else if (wr && paddr_i == `ERPC_OFS_CTRL) begin
         clr_r <= {pwdata_i[`ERPC_CTRL_CLR1], pwdata_i[`ERPC_CTRL_CLR0]};
      end else begin
         clr_r <= 2'h0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         mode_r[0]  <= ERPC_NONE;
         start_r[0] <= `ERPC_RST_EVMASK;
         stop_r[0]  <= `ERPC_RST_EVMASK;
      end else if (wr) begin
         if (paddr_i == `ERPC_OFS_MODE0)  mode_r[0]  <= to_mode(pwdata_i);
         if (paddr_i == `ERPC_OFS_START0) start_r[0] <= pwdata_i[`ERPC_EV_W-1:0];
         if (paddr_i == `ERPC_OFS_STOP0)  stop_r[0]  <= pwdata_i[`ERPC_EV_W-1:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         mode_r[1]  <= ERPC_NONE;
         start_r[1] <= `ERPC_RST_EVMASK;
         stop_r[1]  <= `ERPC_RST_EVMASK;
      end else if (wr && !REDUCED) begin
         if (paddr_i == `ERPC_OFS_MODE1)  mode_r[1]  <= to_mode(pwdata_i);
         if (paddr_i == `ERPC_OFS_START1) start_r[1] <= pwdata_i[`ERPC_EV_W-1:0];
         if (paddr_i == `ERPC_OFS_STOP1)  stop_r[1]  <= pwdata_i[`ERPC_EV_W-1:0];
      end
   end

   // ---- range engines ----
   assign rif[0].mode       = mode_r[0];
   assign rif[0].start_mask = start_r[0];
   assign rif[0].stop_mask  = stop_r[0];
   // second range settings are dropped while cascaded
   assign rif[1].mode       = (casc_r || REDUCED) ? ERPC_NONE : mode_r[1];
   assign rif[1].start_mask = start_r[1];
   assign rif[1].stop_mask  = stop_r[1];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_rng
         erpc_range u_rng (
            .sys_clk_i    (sys_clk_i),
            .reset_n_i    (reset_n_i),
            .ev_match_i   (ev_match_i),
            .cpu_run_i    (cpu_run_i),
            .cpu_super_i  (cpu_super_i),
            .exc_cyc_i    (exc_cyc_i),
            .irq_cyc_i    (irq_cyc_i),
            .instr_exec_i (instr_exec_i),
            .exc_acc_i    (exc_acc_i),
            .irq_acc_i    (irq_acc_i),
            .rif          (rif[g])
         );
         assign act[g]  = rif[g].active;
         assign pend[g] = rif[g].pass_end;
      end
   endgenerate

   // ---- counters ----
   assign cnt_inc[0] = rif[0].inc;
   assign cnt_inc[1] = casc_r ? carry[0] : rif[1].inc;

   erpc_cnt #(.W(CW)) u_cnt0 (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .clr_i     (clr_r[0]),
      .inc_i     (cnt_inc[0]),
      .cnt_o     (cnt[0]),
      .carry_o   (carry[0])
   );

   generate
      if (REDUCED) begin : g_red
         assign cnt[1]   = '0;
         assign carry[1] = 1'b0;
      end else begin : g_full
         // cascade clears both halves together
         erpc_cnt #(.W(CW)) u_cnt1 (
            .sys_clk_i (sys_clk_i),
            .reset_n_i (reset_n_i),
            .clr_i     (clr_r[1] | (casc_r & clr_r[0])),
            .inc_i     (cnt_inc[1]),
            .cnt_o     (cnt[1]),
            .carry_o   (carry[1])
         );
      end
   endgenerate

   // ---- status and interrupt ----
   always_comb begin
      ev_set = '0;
      ev_set[`ERPC_ST_OVF0] = casc_r ? carry[1] : carry[0];
      ev_set[`ERPC_ST_OVF1] = ~casc_r & carry[1];
      ev_set[`ERPC_ST_END0] = pend[0];
      ev_set[`ERPC_ST_END1] = pend[1];
   end

   // new events win over a same-cycle clear
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         status_r <= '0;
      end else if (wr && paddr_i == `ERPC_OFS_STATUS) begin
         status_r <= (status_r & ~pwdata_i[`ERPC_ST_W-1:0]) | ev_set;
      end else begin
         status_r <= status_r | ev_set;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i)                          mask_r <= `ERPC_RST_MASK;
      else if (wr && paddr_i == `ERPC_OFS_MASK) mask_r <= pwdata_i[`ERPC_ST_W-1:0];
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) irq_r <= 1'b0;
      else            irq_r <= |(status_r & mask_r);
   end

   // ---- apb answer, one wait state ----
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= acc;
         pslverr_r <= acc & ~mapped(paddr_i);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         prdata_r <= 32'h0000_0000;
      end else if (acc && !pwrite_i) begin
         unique case (paddr_i)
            `ERPC_OFS_CTRL:   prdata_r <= {31'h0, casc_r};
            `ERPC_OFS_MODE0:  prdata_r <= 32'(mode_r[0]);
            `ERPC_OFS_START0: prdata_r <= 32'(start_r[0]);
            `ERPC_OFS_STOP0:  prdata_r <= 32'(stop_r[0]);
            `ERPC_OFS_MODE1:  prdata_r <= 32'(mode_r[1]);
            `ERPC_OFS_START1: prdata_r <= 32'(start_r[1]);
            `ERPC_OFS_STOP1:  prdata_r <= 32'(stop_r[1]);
            `ERPC_OFS_CNT0:   prdata_r <= 32'(cnt[0]);
            `ERPC_OFS_CNT1:   prdata_r <= 32'(cnt[1]);
            `ERPC_OFS_STATUS: prdata_r <= 32'(status_r);
            `ERPC_OFS_MASK:   prdata_r <= 32'(mask_r);
            `ERPC_OFS_STATE:  prdata_r <= {30'h0, act[NR-1:0] == '0 ? 2'h0 : act};
            default:          prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   assign prdata_o  = prdata_r;
   assign pready_o  = pready_r;
   assign pslverr_o = pslverr_r;
   assign irq_o     = irq_r;

endmodule

// file: test/erpc_cpu_model.sv
/*
 * CPU-side source of status levels, pulses and detector hits.
 * Assumes the bench supplies random bits and hit requests each cycle.
 */
`timescale 1ns/1ps
module erpc_cpu_model (
   input  wire logic        sys_clk_i, // cpu clock
   input  wire logic [31:0] rnd_i,     // random bits
   input  wire logic [7:0]  ev_req_i,  // hit requests
   input  wire logic        run_req_i, // run request
   output logic [7:0]       ev_o,      // match pulses
   output logic             run_o,     // executing
   output logic [2:0]       lvl_o,     // irq, exc, super
   output logic [2:0]       acc_o      // irq, exc, exec pulses
);
   initial {ev_o, run_o, lvl_o, acc_o} = '0;
   always @(posedge sys_clk_i) begin
      ev_o <= ev_req_i;
      run_o <= run_req_i;
      lvl_o <= {rnd_i[3] & rnd_i[4], rnd_i[1] & rnd_i[2], rnd_i[0]};
      acc_o <= rnd_i[7:5] & ~acc_o; // never two cycles in a row
   end
endmodule

// file: test/erpc_top_asserts.sv
/*
 * Bus and interrupt timing checks on the counter's top ports.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "erpc_map.svh"
module erpc_top_asserts (
   input wire logic                    sys_clk_i, // clock
   input wire logic                    reset_n_i, // reset
   input wire logic                    psel_i,    // select
   input wire logic                    penable_i, // enable
   input wire logic                    pwrite_i,  // write
   input wire logic [`ERPC_ADDR_W-1:0] paddr_i,   // address
   input wire logic [31:0]             prdata_o,  // read data
   input wire logic                    pready_o,  // ready
   input wire logic                    pslverr_o, // error
   input wire logic                    irq_o      // interrupt
);
   logic acc;
   assign acc = psel_i && penable_i && !pready_o;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   property p_ready_next; acc |=> pready_o; endproperty
   a_ready_next: assert property (p_ready_next)
      else $error("ready missing after access");
   property p_ready_cause; pready_o |-> $past(psel_i) && $past(penable_i); endproperty
   a_ready_cause: assert property (p_ready_cause)
      else $error("ready without access");
   property p_ready_pulse; pready_o |=> !pready_o; endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready longer than one cycle");
   property p_err_ready; pslverr_o |-> pready_o; endproperty
   a_err_ready: assert property (p_err_ready)
      else $error("error without ready");
   property p_err_gap; acc && (paddr_i == 8'h1C || paddr_i > 8'h30) |=> pslverr_o; endproperty
   a_err_gap: assert property (p_err_gap)
      else $error("unmapped access not flagged");
   property p_ok_mapped;
      acc && paddr_i[1:0] == 2'h0 && paddr_i <= 8'h30 && paddr_i != 8'h1C |=> !pslverr_o;
   endproperty
   a_ok_mapped: assert property (p_ok_mapped)
      else $error("mapped access flagged");
   property p_rd_hold; !pready_o |-> $stable(prdata_o); endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved while idle");
   property p_irq_fall; $fell(irq_o) |-> $past(pready_o) && $past(pwrite_i); endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt dropped without a write");
endmodule

bind erpc_top erpc_top_asserts i_erpc_top_asserts (.sys_clk_i(sys_clk_i),
   .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .irq_o(irq_o));

// file: test/tb_top.sv
/*
 * Self-checking bench for the event range performance counter.
 * Assumes the full variant, the cpu model and the bound checker.
 */
`timescale 1ns/1ps
`include "erpc_map.svh"
module tb_top;
   import erpc_pkg::*;
   logic        sys_clk_i = 0;
   logic        reset_n_i = 0;
   logic        psel_i = 0;
   logic        penable_i = 0;
   logic        pwrite_i = 0;
   logic [7:0]  paddr_i = '0;
   logic [31:0] pwdata_i = '0;
   logic [31:0] rnd = 32'h0000FEDA;
   logic [7:0]  ev_req = '0;
   logic        run_req = 0;
   logic        prev_run = 0;
   logic [31:0] prdata_o, rd;
   logic        pready_o, pslverr_o, irq_o, perr, cpu_run_i;
   logic [7:0]  ev_match_i;
   logic [2:0]  lvl, acc;
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          mst = 0;
   int          mcas = 0;
   int          mm[2], ms[2], mp[2], mc[2], ma[2], mv[2];

   erpc_top i_erpc_top (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .ev_match_i(ev_match_i), .cpu_run_i(cpu_run_i), .cpu_super_i(lvl[0]),
      .exc_cyc_i(lvl[1]), .irq_cyc_i(lvl[2]), .instr_exec_i(acc[0]),
      .exc_acc_i(acc[1]), .irq_acc_i(acc[2]), .irq_o(irq_o));
   erpc_cpu_model i_erpc_cpu_model (.sys_clk_i(sys_clk_i), .rnd_i(rnd), .ev_req_i(ev_req),
      .run_req_i(run_req), .ev_o(ev_match_i), .run_o(cpu_run_i), .lvl_o(lvl), .acc_o(acc));

   always #20 sys_clk_i = ~sys_clk_i;

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction

   function automatic bit qual(input int m);
      case (m)
         1: return cpu_run_i;
         2: return cpu_run_i & lvl[0];
         3: return lvl[1] | lvl[2];
         4: return lvl[1];
         5: return lvl[2];
         6: return acc[0];
         7: return acc[1] | acc[2];
         8: return acc[1];
         9: return acc[2];
         default: return 0;
      endcase
   endfunction

   // reference model, one step per edge from the values at the inputs
   always @(posedge sys_clk_i) begin
      bit st, sp;
      rnd <= xs(rnd);
      cyc++;
      if (cyc > 20000) begin
         n_mismatch++;
         end_of_test;
      end
      for (int r = 0; r < 2; r++) begin
         st = ms[r] != 0 ? |(ev_match_i & ms[r][7:0]) : cpu_run_i & !prev_run;
         sp = mp[r] != 0 ? |(ev_match_i & mp[r][7:0]) : !cpu_run_i & prev_run;
         if (mm[r] == 0 || (r == 1 && mcas == 1)) begin
            ma[r] = 0;
            mv[r] = 0;
         end else if (ma[r] == 1) begin
            if (qual(mm[r])) begin
               if (mm[r] < 6) mc[r]++;
               else mv[r] = 1;
            end
            if (sp) begin
               if (mv[r] == 1) mc[r]++;
               mst |= 4 << r; // pass end flagged in every mode
               ma[r] = 0;
               mv[r] = 0;
            end
         end else if (st) ma[r] = 1;
      end
      prev_run = cpu_run_i;
   end

   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel_i <= 1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1;
      do begin
         @(posedge sys_clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      perr = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
      @(posedge sys_clk_i);
   endtask

   task automatic rdc(input logic [7:0] a, input int exp);
      apb(0, a, '0);
      cmp(rd, 32'(exp));
   endtask

   task automatic setr(input int r, input int m, input int s, input int p);
      apb(1, 8'h04 + 8'(r * 12), 32'(m));
      apb(1, 8'h08 + 8'(r * 12), 32'(s));
      apb(1, 8'h0C + 8'(r * 12), 32'(p));
      mm[r] = m;
      ms[r] = s;
      mp[r] = p;
   endtask

   task automatic ev(input logic [7:0] m, input int w);
      ev_req <= m;
      @(posedge sys_clk_i);
      ev_req <= '0;
      repeat (w) @(posedge sys_clk_i);
   endtask

   initial begin
      static logic [7:0] regs[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h24, 8'h28,
                                     8'h30};
      repeat (10) @(posedge sys_clk_i);
      reset_n_i <= 1;
      @(posedge sys_clk_i);
      foreach (regs[i]) rdc(regs[i], 0);
      apb(0, 8'h1C, 32'hFFFFFFFF);
      cmp(rd, 32'h0);
      cmp({31'h0, perr}, 32'h1);
      apb(1, 8'h04, 32'hF);
      rdc(8'h04, 0);
      apb(1, 8'h2C, 32'h4);
      run_req <= 1;
      for (int m = 1; m < 10; m++) begin
         int em;
         em = 12;
         setr(0, m, 8'h01, 8'h02);
         setr(1, 10 - m, 8'h0C, 8'h10);
         apb(1, 8'h00, 32'h6);
         apb(1, 8'h28, 32'hF);
         mc = '{0, 0};
         mst = 0;
         repeat (2) begin
            ev(8'h01 | 8'(4 << (m & 1)), 2);
            rdc(8'h30, 3);
            repeat (10 + rnd[3:0]) @(posedge sys_clk_i);
            ev(8'h12, 3);
         end
         rdc(8'h20, mc[0]);
         rdc(8'h24, mc[1]);
         apb(0, 8'h28, '0);
         cmp(rd & 32'(em), 32'(mst));
         cmp({31'h0, irq_o}, 32'h1);
      end
      apb(1, 8'h28, 32'hF);
      @(posedge sys_clk_i);
      cmp({31'h0, irq_o}, 32'h0);
      apb(1, 8'h00, 32'h7);
      mcas = 1;
      mc = '{0, 0};
      setr(0, ERPC_EXEC_CYC, 8'h01, 8'h02);
      setr(1, ERPC_IRQ_CNT, 8'h01, 8'h02);
      ev(8'h01, 2);
      rdc(8'h30, 1);
      repeat (30) @(posedge sys_clk_i);
      ev(8'h02, 3);
      rdc(8'h20, mc[0]);
      rdc(8'h24, 0);
      apb(1, 8'h00, 32'h0);
      mcas = 0;
      setr(1, ERPC_NONE, 0, 0);
      setr(0, ERPC_EXCIRQ_CYC, 0, 0);
      run_req <= 0;
      apb(1, 8'h00, 32'h2);
      mc = '{0, 0};
      run_req <= 1;
      repeat (40) @(posedge sys_clk_i);
      rdc(8'h30, 1);
      run_req <= 0;
      repeat (4) @(posedge sys_clk_i);
      rdc(8'h20, mc[0]);
      rdc(8'h30, 0);
      end_of_test;
   end
endmodule
